// *** rtl/rmvt_pkg.sv ***
// rmvt_pkg: register map, field layout, reset values and states of the table access block
// assumes a 32-bit AXI4-Lite slave with each register on one aligned word
package rmvt_pkg;
  localparam logic [15:0] VL_ENTRY0_OFS = 16'h0400;
  localparam logic [15:0] VL_ENTRY1_OFS = 16'h0404;
  localparam logic [15:0] VL_ENTRY2_OFS = 16'h0408;
  localparam logic [15:0] VL_INDEX_OFS = 16'h040C;
  localparam logic [15:0] VL_CTRL_OFS = 16'h0410;
  localparam logic [15:0] SA_CTRL_OFS = 16'h041C;
  localparam logic [15:0] MC_ENTRY_OFS = 16'h0424;
  localparam int ADDR_W = 16;
  localparam int PORT_N = 7;
  localparam int MC_ROWS = 48;
  localparam int MC_GROUPS = 8;
  localparam int VID_W = 12;
  localparam int VL_DEPTH = 4096;
  localparam int RSV_MASK_BIT = 4;
  // shared control register fields
  localparam int SA_IDX_LSB = 0;
  localparam int SA_IDX_W = 6;
  localparam int SA_SEL_BIT = 8;
  localparam int SA_ACT_BIT = 9;
  localparam int SA_GO_BIT = 15;
  // reserved multicast entry register
  localparam int MC_RSV_LSB = 30;
  // VLAN control register
  localparam int VL_ACT_BIT = 0;
  localparam int VL_GO_BIT = 7;
  // VLAN entry 0 fields
  localparam int VE_VALID_BIT = 31;
  localparam int VE_FWDOPT_BIT = 30;
  localparam int VE_FGID_LSB = 16;
  localparam int VE_PRIO_LSB = 8;
  localparam int VE_STI_LSB = 0;
  localparam int VE_FGID_W = 7;
  localparam int VE_PRIO_W = 3;
  localparam int VE_STI_W = 3;
  // packed entry: valid, fwdopt, prio, sti, fgid, untag, member
  localparam int VE_W = 2 + VE_PRIO_W + VE_STI_W + VE_FGID_W + 2 * PORT_N;
  localparam logic [31:0] RESET_VAL = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_MC, ST_VWR, ST_VRD, ST_VLD} rmvt_state_t;
endpackage

// *** rtl/rmvt_table_access.sv ***
// rmvt_table_access: indirect host access to the reserved multicast and VLAN tables,
// plus the lookup ports used by the forwarding engine
// assumes lookup inputs and vlan_mode_en come from logic on clk; static table lives elsewhere
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rmvt_table_access (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [rmvt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rmvt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vlan_mode_en,
  input wire logic [5:0] mc_lookup_addr,
  output logic [rmvt_pkg::PORT_N-1:0] mc_forward_mask,
  input wire logic vl_lookup_req,
  input wire logic [rmvt_pkg::VID_W-1:0] vl_lookup_vid,
  output logic vl_lookup_done,
  output logic vl_lookup_valid,
  output logic vl_lookup_fwd_opt,
  output logic [2:0] vl_lookup_priority,
  output logic [2:0] vl_lookup_spanning_tree_instance,
  output logic [6:0] vl_lookup_filter_group_id,
  output logic [rmvt_pkg::PORT_N-1:0] vl_lookup_untag,
  output logic [rmvt_pkg::PORT_N-1:0] vl_lookup_member
);
  import rmvt_pkg::*;

  rmvt_state_t state_q;
  logic aw_full_q, w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_en;
  logic busy;
  logic [31:0] rd_word;
  logic rd_hit;
  // host control and data registers
  logic [SA_IDX_W-1:0] mc_index_q;
  logic mc_sel_q, mc_act_rd_q, go_mc_q;
  logic [PORT_N-1:0] mc_fwd_q;
  logic [1:0] mc_rsv_q;
  logic [PORT_N-1:0] mc_mask_q [MC_GROUPS];
  logic [VID_W-1:0] vl_index_q;
  logic vl_act_rd_q, go_vl_q;
  logic vl_valid_q, vl_fwdopt_q;
  logic [VE_PRIO_W-1:0] vl_prio_q;
  logic [VE_STI_W-1:0] vl_sti_q;
  logic [VE_FGID_W-1:0] vl_fgid_q;
  logic [PORT_N-1:0] vl_untag_q, vl_member_q;
  logic [VE_W-1:0] vl_mem [VL_DEPTH];
  logic [VE_W-1:0] vl_host_rd_q, vl_lu_rd_q;
  logic vl_lu_done_q;
  logic [2:0] mc_grp;
  logic [31:0] mc_merged, vl_idx_merged;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // group of a reserved row: the low three index bits pick one of eight shared masks
  function automatic logic [2:0] row_group(input logic [5:0] row);
    return row[2:0];
  endfunction

  assign busy = (state_q != ST_IDLE);
  assign mc_grp = row_group(mc_index_q);
  assign mc_merged = merge({mc_rsv_q, {(MC_RSV_LSB-PORT_N){1'b0}}, mc_fwd_q}, wdata_q, wstrb_q);
  assign vl_idx_merged = merge(32'(vl_index_q), wdata_q, wstrb_q);

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = ce & ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign wr_en = ce & aw_full_q & w_full_q & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_full_q <= 1'b0;
      wdata_q <= RESET_VAL;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_en) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == VL_ENTRY0_OFS || awaddr_q == VL_ENTRY1_OFS || awaddr_q == VL_ENTRY2_OFS ||
                        awaddr_q == VL_INDEX_OFS || awaddr_q == VL_CTRL_OFS || awaddr_q == SA_CTRL_OFS ||
                        awaddr_q == MC_ENTRY_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode; go flags read back live so software can poll them
  always_comb begin
    rd_word = RESET_VAL;
    rd_hit = 1'b1;
    if (s_axi_araddr == SA_CTRL_OFS) begin
      rd_word[SA_IDX_LSB +: SA_IDX_W] = mc_index_q;
      rd_word[SA_SEL_BIT] = mc_sel_q;
      rd_word[SA_ACT_BIT] = mc_act_rd_q;
      rd_word[SA_GO_BIT] = go_mc_q;
    end else if (s_axi_araddr == MC_ENTRY_OFS) begin
      rd_word[MC_RSV_LSB +: 2] = mc_rsv_q;
      rd_word[PORT_N-1:0] = mc_fwd_q;
    end else if (s_axi_araddr == VL_ENTRY0_OFS) begin
      rd_word[VE_VALID_BIT] = vl_valid_q;
      rd_word[VE_FWDOPT_BIT] = vl_fwdopt_q;
      rd_word[VE_FGID_LSB +: VE_FGID_W] = vl_fgid_q;
      rd_word[VE_PRIO_LSB +: VE_PRIO_W] = vl_prio_q;
      rd_word[VE_STI_LSB +: VE_STI_W] = vl_sti_q;
    end else if (s_axi_araddr == VL_ENTRY1_OFS) begin
      rd_word[PORT_N-1:0] = vl_untag_q;
    end else if (s_axi_araddr == VL_ENTRY2_OFS) begin
      rd_word[PORT_N-1:0] = vl_member_q;
    end else if (s_axi_araddr == VL_INDEX_OFS) begin
      rd_word[VID_W-1:0] = vl_index_q;
    end else if (s_axi_araddr == VL_CTRL_OFS) begin
      rd_word[VL_ACT_BIT] = vl_act_rd_q;
      rd_word[VL_GO_BIT] = go_vl_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RESET_VAL;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- command state machine ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (go_mc_q) begin
            state_q <= ST_MC;
          end else if (go_vl_q) begin
            state_q <= vl_act_rd_q ? ST_VRD : ST_VWR;
          end
        end
        ST_MC: state_q <= ST_IDLE;
        ST_VWR: state_q <= ST_IDLE;
        ST_VRD: state_q <= ST_VLD;
        ST_VLD: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // shared control register; a start only lands while idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mc_index_q <= '0;
      mc_sel_q <= 1'b0;
      mc_act_rd_q <= 1'b0;
      go_mc_q <= 1'b0;
    end else if (ce) begin
      if (wr_en && awaddr_q == SA_CTRL_OFS && !busy && !go_mc_q && !go_vl_q) begin
        mc_index_q <= wdata_q[SA_IDX_LSB +: SA_IDX_W];
        mc_sel_q <= wdata_q[SA_SEL_BIT];
        mc_act_rd_q <= wdata_q[SA_ACT_BIT];
        go_mc_q <= wdata_q[SA_GO_BIT];
      end else if (state_q == ST_MC) begin
        go_mc_q <= 1'b0;
      end
    end
  end

  // group masks: one store per group makes every row of a group follow together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int g = 0; g < MC_GROUPS; g++) begin
        mc_mask_q[g] <= '0;
      end
    end else if (ce) begin
      if (state_q == ST_MC && mc_sel_q && !mc_act_rd_q && mc_index_q < SA_IDX_W'(MC_ROWS)) begin
        mc_mask_q[mc_grp] <= mc_fwd_q;
      end
    end
  end

  // reserved multicast data register; bit 4 never stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mc_fwd_q <= '0;
      mc_rsv_q <= '0;
    end else if (ce) begin
      if (state_q == ST_MC && mc_sel_q && mc_act_rd_q) begin
        mc_fwd_q <= (mc_index_q < SA_IDX_W'(MC_ROWS)) ? mc_mask_q[mc_grp] : '0;
      end else if (wr_en && awaddr_q == MC_ENTRY_OFS && !busy) begin
        mc_fwd_q <= mc_merged[PORT_N-1:0] & ~(PORT_N'(1) << RSV_MASK_BIT);
        mc_rsv_q <= mc_merged[MC_RSV_LSB +: 2];
      end
    end
  end

  // frame-side reserved multicast lookup, row from address bits 5:0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mc_forward_mask <= '0;
    end else if (ce) begin
      mc_forward_mask <= (mc_lookup_addr < 6'(MC_ROWS)) ?
                         mc_mask_q[row_group(mc_lookup_addr)] & ~(PORT_N'(1) << RSV_MASK_BIT) : '0;
    end
  end

  // VLAN index and control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vl_index_q <= '0;
      vl_act_rd_q <= 1'b0;
      go_vl_q <= 1'b0;
    end else if (ce) begin
      if (wr_en && awaddr_q == VL_INDEX_OFS && !busy) begin
        vl_index_q <= vl_idx_merged[VID_W-1:0];
      end
      if (wr_en && awaddr_q == VL_CTRL_OFS && !busy && !go_mc_q && !go_vl_q) begin
        vl_act_rd_q <= wdata_q[VL_ACT_BIT];
        go_vl_q <= wdata_q[VL_GO_BIT];
      end else if (state_q == ST_VWR || state_q == ST_VLD) begin
        go_vl_q <= 1'b0;
      end
    end
  end

  // VLAN entry data registers: loaded by host, or by a completed read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vl_valid_q <= 1'b0;
      vl_fwdopt_q <= 1'b0;
      vl_prio_q <= '0;
      vl_sti_q <= '0;
      vl_fgid_q <= '0;
      vl_untag_q <= '0;
      vl_member_q <= '0;
    end else if (ce) begin
      if (state_q == ST_VLD) begin
        {vl_valid_q, vl_fwdopt_q, vl_prio_q, vl_sti_q, vl_fgid_q, vl_untag_q, vl_member_q} <= vl_host_rd_q;
      end else if (wr_en && !busy) begin
        if (awaddr_q == VL_ENTRY0_OFS) begin
          vl_valid_q <= wstrb_q[3] ? wdata_q[VE_VALID_BIT] : vl_valid_q;
          vl_fwdopt_q <= wstrb_q[3] ? wdata_q[VE_FWDOPT_BIT] : vl_fwdopt_q;
          vl_fgid_q <= wstrb_q[2] ? wdata_q[VE_FGID_LSB +: VE_FGID_W] : vl_fgid_q;
          vl_prio_q <= wstrb_q[1] ? wdata_q[VE_PRIO_LSB +: VE_PRIO_W] : vl_prio_q;
          vl_sti_q <= wstrb_q[0] ? wdata_q[VE_STI_LSB +: VE_STI_W] : vl_sti_q;
        end else if (awaddr_q == VL_ENTRY1_OFS && wstrb_q[0]) begin
          vl_untag_q <= wdata_q[PORT_N-1:0];
        end else if (awaddr_q == VL_ENTRY2_OFS && wstrb_q[0]) begin
          vl_member_q <= wdata_q[PORT_N-1:0];
        end
      end
    end
  end

  // VLAN table: one write port for the host, two registered read ports (host and lookup);
  // no reset so it maps onto block RAM, hence software must program it before use
  always_ff @(posedge clk) begin
    if (ce) begin
      if (state_q == ST_VWR) begin
        vl_mem[vl_index_q] <= {vl_valid_q, vl_fwdopt_q, vl_prio_q, vl_sti_q, vl_fgid_q, vl_untag_q, vl_member_q};
      end
      if (state_q == ST_VRD) begin
        vl_host_rd_q <= vl_mem[vl_index_q];
      end
      if (vl_lookup_req) begin
        vl_lu_rd_q <= vl_mem[vl_lookup_vid];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vl_lu_done_q <= 1'b0;
    end else if (ce) begin
      vl_lu_done_q <= vl_lookup_req & vlan_mode_en;
    end
  end

  assign vl_lookup_done = vl_lu_done_q;
  always_comb begin
    {vl_lookup_valid, vl_lookup_fwd_opt, vl_lookup_priority, vl_lookup_spanning_tree_instance,
     vl_lookup_filter_group_id, vl_lookup_untag, vl_lookup_member} = vl_lu_done_q ? vl_lu_rd_q : '0;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_vl_rd_start;
    state_q == ST_IDLE && !go_mc_q && go_vl_q && vl_act_rd_q && ce;
  endsequence
  sequence s_vl_rd_finish;
    state_q == ST_VRD ##1 (state_q == ST_VLD && ce) ##1 !go_vl_q;
  endsequence

  a_mc_go_clear: assert property ((state_q == ST_MC && ce) |=> !go_mc_q && state_q == ST_IDLE)
    else $error("reserved multicast go flag not cleared after access");
  a_mc_read_load: assert property ((state_q == ST_MC && ce && mc_sel_q && mc_act_rd_q && mc_index_q < 6'd48)
    |=> mc_fwd_q == $past(mc_mask_q[mc_grp]))
    else $error("read did not load group mask into data register");
  a_mc_group_share: assert property ((state_q == ST_MC && ce && mc_sel_q && !mc_act_rd_q && mc_index_q < 6'd48)
    |=> mc_mask_q[$past(mc_index_q[2:0])] == $past(mc_fwd_q))
    else $error("group mask not updated by write");
  a_rsv_bit_zero: assert property (mc_forward_mask[4] == 1'b0 && mc_fwd_q[4] == 1'b0)
    else $error("reserved forward bit set");
  a_vl_read_seq: assert property (s_vl_rd_start ##1 ce |-> s_vl_rd_finish)
    else $error("vlan read did not complete in two cycles");
  a_vl_write_clear: assert property ((state_q == ST_VWR && ce) |=> !go_vl_q && state_q == ST_IDLE)
    else $error("vlan go flag not cleared after write");
  a_busy_no_start: assert property ((state_q == ST_MC && !go_vl_q && ce) |=> !go_vl_q)
    else $error("start accepted while busy");
  a_lookup_gated: assert property ((ce && !vlan_mode_en) |=> !vl_lookup_done && !vl_lookup_valid)
    else $error("vlan lookup answered with mode disabled");
  a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule

// *** testbench/reserved_mcast_vlan_table_access_tb.sv ***
// reserved_mcast_vlan_table_access_tb: self-checking bench for the table access block
// assumes the design answers on AXI4-Lite with bvalid/rvalid levels and registered lookup results
`timescale 1ns/100ps
module reserved_mcast_vlan_table_access_tb;
  import rmvt_pkg::*;
  typedef struct packed {logic [11:0] vid; logic [31:0] e0; logic [31:0] e1; logic [31:0] e2;} rmvt_vrow_t;
  typedef struct packed {logic [5:0] row; logic [5:0] mate; logic [6:0] mask; logic [6:0] exp;} rmvt_mrow_t;
  logic clk, resetn, ce;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic vlan_mode_en, vl_lookup_req, vl_lookup_done, vl_lookup_valid, vl_lookup_fwd_opt;
  logic [5:0] mc_lookup_addr;
  logic [PORT_N-1:0] mc_forward_mask, vl_lookup_untag, vl_lookup_member;
  logic [VID_W-1:0] vl_lookup_vid;
  logic [2:0] vl_lookup_priority, vl_lookup_spanning_tree_instance;
  logic [6:0] vl_lookup_filter_group_id;
  int fails, n_compared;
  logic [31:0] rd;
  logic [1:0] rsp;
  rmvt_vrow_t vrows [3];
  rmvt_mrow_t mrows [3];

  rmvt_table_access i_rmvt_table_access (
    .clk(clk), .resetn(resetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .vlan_mode_en(vlan_mode_en),
    .mc_lookup_addr(mc_lookup_addr), .mc_forward_mask(mc_forward_mask), .vl_lookup_req(vl_lookup_req),
    .vl_lookup_vid(vl_lookup_vid), .vl_lookup_done(vl_lookup_done), .vl_lookup_valid(vl_lookup_valid),
    .vl_lookup_fwd_opt(vl_lookup_fwd_opt), .vl_lookup_priority(vl_lookup_priority),
    .vl_lookup_spanning_tree_instance(vl_lookup_spanning_tree_instance),
    .vl_lookup_filter_group_id(vl_lookup_filter_group_id), .vl_lookup_untag(vl_lookup_untag),
    .vl_lookup_member(vl_lookup_member)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // every bus task starts and ends just after a rising edge, so all drives are non-blocking
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 200 && !(aw_ok && w_ok); t++) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    if (s_axi_bvalid !== 1'b1) begin
      fails++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge so the next call never re-drives bready in the same step
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (s_axi_arready !== 1'b1 && t < 200);
    s_axi_arvalid <= 1'b0;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    if (s_axi_rvalid !== 1'b1) begin
      fails++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // go flag must fall within a bounded number of polls
  task automatic poll_go(input logic [15:0] a, input int b);
    int t;
    logic [31:0] d;
    logic [1:0] r;
    t = 0;
    do begin
      axi_read(a, d, r);
      t++;
    end while (d[b] !== 1'b0 && t < 20);
    check({31'h0, d[b]}, 32'h0);
  endtask

  task automatic mc_look(input logic [5:0] a, input logic [6:0] exp);
    mc_lookup_addr <= a;
    // the answer registered at the first edge is read at the second, before it updates
    @(posedge clk);
    @(posedge clk);
    check({25'h0, mc_forward_mask}, {25'h0, exp});
  endtask

  task automatic vl_look(input logic [11:0] v, input logic en, input rmvt_vrow_t e);
    vlan_mode_en <= en;
    vl_lookup_vid <= v;
    vl_lookup_req <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check({31'h0, vl_lookup_done}, {31'h0, en});
    if (en) begin
      check({24'h0, vl_lookup_valid, vl_lookup_fwd_opt, vl_lookup_priority, vl_lookup_spanning_tree_instance},
            {24'h0, e.e0[31:30], e.e0[10:8], e.e0[2:0]});
      check({11'h0, vl_lookup_filter_group_id, vl_lookup_untag, vl_lookup_member},
            {11'h0, e.e0[22:16], e.e1[6:0], e.e2[6:0]});
    end
    vl_lookup_req <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    vlan_mode_en = 1'b0;
    mc_lookup_addr = 6'h0;
    vl_lookup_req = 1'b0;
    vl_lookup_vid = 12'h0;
    fails = 0;
    n_compared = 0;
    vrows[0] = '{12'h000, 32'hC07F0707, 32'h0000007F, 32'h0000007F};
    vrows[1] = '{12'hFFF, 32'h80550502, 32'h00000015, 32'h0000002A};
    vrows[2] = '{12'h123, 32'h402A0305, 32'h00000040, 32'h00000001};
    // mate shares low three bits with row, so it lands in the same group
    mrows[0] = '{6'h00, 6'h08, 7'h7F, 7'h6F};
    mrows[1] = '{6'h2F, 6'h27, 7'h15, 7'h05};
    mrows[2] = '{6'h0D, 6'h2D, 7'h2A, 7'h2A};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    axi_read(MC_ENTRY_OFS, rd, rsp);
    check(rd, RESET_VAL);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    mc_look(6'h00, 7'h00);
    foreach (mrows[i]) begin
      wr(MC_ENTRY_OFS, {25'h0, mrows[i].mask});
      wr(SA_CTRL_OFS, 32'h00008100 | mrows[i].row);
      poll_go(SA_CTRL_OFS, SA_GO_BIT);
    end
    // a row above 47 aliases group 0 by its low bits and must not touch it
    wr(MC_ENTRY_OFS, 32'h00000001);
    wr(SA_CTRL_OFS, 32'h00008130);
    poll_go(SA_CTRL_OFS, SA_GO_BIT);
    foreach (mrows[i]) begin
      wr(SA_CTRL_OFS, 32'h00008300 | mrows[i].mate);
      poll_go(SA_CTRL_OFS, SA_GO_BIT);
      axi_read(MC_ENTRY_OFS, rd, rsp);
      check(rd & 32'h0000007F, {25'h0, mrows[i].exp});
      mc_look(mrows[i].mate, mrows[i].exp);
    end
    mc_look(6'h32, 7'h00);
    wr(SA_CTRL_OFS, 32'h00008332);
    poll_go(SA_CTRL_OFS, SA_GO_BIT);
    axi_read(MC_ENTRY_OFS, rd, rsp);
    check(rd & 32'h0000007F, 32'h0);
    wr(SA_CTRL_OFS, 32'h00008000);
    poll_go(SA_CTRL_OFS, SA_GO_BIT);
    foreach (vrows[i]) begin
      wr(VL_ENTRY0_OFS, vrows[i].e0);
      wr(VL_ENTRY1_OFS, vrows[i].e1);
      wr(VL_ENTRY2_OFS, vrows[i].e2);
      wr(VL_INDEX_OFS, {20'h0, vrows[i].vid});
      wr(VL_CTRL_OFS, 32'h00000080);
      poll_go(VL_CTRL_OFS, VL_GO_BIT);
    end
    foreach (vrows[i]) begin
      wr(VL_ENTRY0_OFS, 32'h0);
      wr(VL_ENTRY1_OFS, 32'h0);
      wr(VL_ENTRY2_OFS, 32'h0);
      wr(VL_INDEX_OFS, {20'h0, vrows[i].vid});
      wr(VL_CTRL_OFS, 32'h00000081);
      poll_go(VL_CTRL_OFS, VL_GO_BIT);
      axi_read(VL_ENTRY0_OFS, rd, rsp);
      check(rd, vrows[i].e0);
      axi_read(VL_ENTRY1_OFS, rd, rsp);
      check(rd, vrows[i].e1);
      axi_read(VL_ENTRY2_OFS, rd, rsp);
      check(rd, vrows[i].e2);
      vl_look(vrows[i].vid, 1'b1, vrows[i]);
    end
    vl_look(vrows[0].vid, 1'b0, vrows[0]);
    // top byte only: other fields keep the last read result; bits 31:30 (valid/fwdopt, multicast reserved) take the write
    s_axi_wstrb <= 4'h8;
    wr(VL_ENTRY0_OFS, 32'hC0000000);
    wr(MC_ENTRY_OFS, 32'hC000007F);
    s_axi_wstrb <= 4'hF;
    axi_read(VL_ENTRY0_OFS, rd, rsp);
    check(rd, 32'hC02A0305);
    axi_read(MC_ENTRY_OFS, rd, rsp);
    check(rd, 32'hC0000000);
    axi_write(16'h0500, 32'h12345678, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_read(16'h0500, rd, rsp);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    // clock enable low: lookup answer frozen, bus refuses
    mc_look(mrows[1].mate, mrows[1].exp);
    ce <= 1'b0;
    mc_lookup_addr <= mrows[0].mate;
    repeat (2) @(posedge clk);
    check({31'h0, s_axi_awready}, 32'h0);
    check({25'h0, mc_forward_mask}, {25'h0, mrows[1].exp});
    ce <= 1'b1;
    @(posedge clk);
    // reset in mid-run returns the control register and group masks to zero
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    axi_read(SA_CTRL_OFS, rd, rsp);
    check(rd, RESET_VAL);
    mc_look(mrows[0].mate, 7'h00);
    end_sim();
  end
endmodule
